// ### fpes_sequencer.sv
// Purpose: Host controller issuing program, erase, suspend sequences
// Assumes: Flash device on parallel pins, status via polling
// Notes:   Accel pin control is a user level gated by unlocked_i
`timescale 1ns/1ps
`include "fpes_map.svh"
module fpes_sequencer
  import fpes_pkg::*;
#(
  parameter int CNT_W    = 8,                 // Buffer count width
  parameter int MAX_WORDS = 128               // Write buffer size
)
(
  input  wire logic        clk_i,             // Clock, 25 MHz
  input  wire logic        reset_n_i,         // Async reset, active low
  input  wire logic        start_i,           // Start operation, pulse
  input  wire logic [2:0]  op_i,              // Operation code
  input  wire logic [23:0] sect_addr_i,       // Sector address
  input  wire logic [CNT_W-1:0] count_i,      // Words minus one
  input  wire logic        more_sect_i,       // Another sector follows
  input  wire logic        accel_en_i,        // Request high voltage
  input  wire logic        unlocked_i,        // Sectors unlocked
  input  wire logic [23:0] wr_addr_i,         // Buffer word address
  input  wire logic [15:0] wr_data_i,         // Buffer word data
  output logic             wr_ready_o,        // Ready for buffer word
  input  wire logic        wr_valid_i,        // Buffer word valid
  output logic             busy_o,            // Operation running
  output logic             done_o,            // Operation ended, pulse
  output logic             pass_o,            // Last operation passed
  output logic             fail_o,            // Timeout fail seen
  output logic             aborted_o,         // Buffer abort seen
  output logic             accel_hv_o,        // High voltage select
  output logic [23:0]      fl_addr_o,         // Flash address
  output logic [15:0]      fl_dq_o,           // Flash data out
  output logic             fl_dq_oe_o,        // Flash data enable
  input  wire logic [15:0] fl_dq_i,           // Flash data in
  output logic             fl_we_n_o,         // Flash write strobe
  output logic             fl_oe_n_o          // Flash output enable
);
  // Elaboration check: count register must hold the buffer size
  if (MAX_WORDS > (1 << CNT_W))
    $error("Count width too small");

  fpes_wr_if cyc ();
  fpes_bus_cycle u_cyc (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .cyc       (cyc),
    .addr_o    (fl_addr_o),
    .dq_o      (fl_dq_o),
    .dq_oe_o   (fl_dq_oe_o),
    .dq_i      (fl_dq_i),
    .we_n_o    (fl_we_n_o),
    .oe_n_o    (fl_oe_n_o)
  );

  //----------------------------------------------------------
  // Sequencer state
  //----------------------------------------------------------
  fpes_state_t       st_reg, st_next;       // Main state
  fpes_op_t          op_reg, op_next;       // Current operation
  logic [2:0]        idx_reg, idx_next;     // Step within sequence
  logic [CNT_W-1:0]  wc_reg, wc_next;       // Remaining load count
  logic [23:0]       sa_reg, sa_next;       // Selected sector
  logic [23:0]       la_reg, la_next;       // Last loaded address
  logic [15:0]       ld_reg, ld_next;       // Last loaded data
  logic [15:0]       gap_reg, gap_next;     // Sector gap timer
  logic [15:0]       rs_reg, rs_next;       // Resume-to-suspend timer
  logic              pass_reg, pass_next;   // Pass flag
  logic              fail_reg, fail_next;   // Fail flag
  logic              abt_reg, abt_next;     // Abort flag
  logic              done_reg, done_next;   // Done pulse
  logic              hv_reg, hv_next;       // High voltage select

  // Step table: address and data of unlock-style writes
  function automatic logic [39:0] step_word(input fpes_op_t op, input logic [2:0] i,
                                            input logic [23:0] sa);
    logic [39:0] w;
    case (i)
      3'h1, 3'h4: w = {`FPES_UNLOCK_ADDR2, `FPES_UNLOCK_DATA2};
      3'h2: w = (op == FPES_OP_BUF_PROG) ? {sa, `FPES_CMD_WB_LOAD}
              : (op == FPES_OP_ABORT_RST) ? {`FPES_UNLOCK_ADDR1, `FPES_CMD_ABORT_RESET}
              : {`FPES_UNLOCK_ADDR1, `FPES_CMD_ERASE_SETUP};
      3'h5: w = (op == FPES_OP_CHIP_ERASE) ? {`FPES_UNLOCK_ADDR1, `FPES_CMD_CHIP_ERASE}
              : {sa, `FPES_CMD_SECT_ERASE};
      default: w = {`FPES_UNLOCK_ADDR1, `FPES_UNLOCK_DATA1};
    endcase
    return w;
  endfunction : step_word

  // Index of last step per operation
  function automatic logic [2:0] step_last(input fpes_op_t op);
    case (op)
      FPES_OP_CHIP_ERASE, FPES_OP_SECT_ERASE: return 3'h5;
      FPES_OP_BUF_PROG, FPES_OP_ABORT_RST:    return 3'h2;
      default:                                return 3'h0;
    endcase
  endfunction : step_last

  logic [39:0] sw;   // Current step word
  always_comb sw = step_word(op_reg, idx_reg, sa_reg);

  // Next-state logic
  always_comb
  begin
    st_next   = st_reg;
    op_next   = op_reg;
    idx_next  = idx_reg;
    wc_next   = wc_reg;
    sa_next   = sa_reg;
    la_next   = la_reg;
    ld_next   = ld_reg;
    gap_next  = (gap_reg != 16'h0) ? gap_reg - 16'h1 : 16'h0;
    rs_next   = (rs_reg != 16'h0) ? rs_reg - 16'h1 : 16'h0;
    pass_next = pass_reg;
    fail_next = fail_reg;
    abt_next  = abt_reg;
    done_next = 1'b0;
    hv_next   = accel_en_i && unlocked_i;
    cyc.req   = 1'b0;
    cyc.rd    = 1'b0;
    cyc.addr  = sw[39:16];
    cyc.wdata = sw[15:0];
    wr_ready_o = 1'b0;
    case (st_reg)
      FPES_IDLE:
      begin
        if (start_i && !(op_i == FPES_OP_SUSPEND && rs_reg != 16'h0))
        begin
          op_next   = fpes_op_t'(op_i);
          sa_next   = sect_addr_i;
          wc_next   = count_i;
          idx_next  = 3'h0;
          pass_next = 1'b0;
          fail_next = 1'b0;
          abt_next  = 1'b0;
          st_next   = FPES_ISSUE;
        end
      end
      FPES_ISSUE:
      begin
        cyc.req = 1'b1;
        if (op_reg == FPES_OP_SUSPEND)
          cyc.wdata = `FPES_CMD_PGM_SUSPEND;
        else if (op_reg == FPES_OP_RESUME)
          cyc.wdata = `FPES_CMD_PGM_RESUME;
        else if (op_reg == FPES_OP_RESET)
          cyc.wdata = `FPES_CMD_RESET;
        if (cyc.ack)
        begin
          if (idx_reg != step_last(op_reg))
            idx_next = idx_reg + 3'h1;
          else if (op_reg == FPES_OP_BUF_PROG)
          begin
            idx_next = 3'h0;
            st_next  = FPES_DATA;
          end
          else if (op_reg == FPES_OP_SECT_ERASE)
          begin
            gap_next = 16'(`FPES_SECT_GAP_CYC);
            st_next  = FPES_SECTW;
          end
          else
          begin
            if (op_reg == FPES_OP_RESUME)
              rs_next = 16'(`FPES_RES_SUS_CYC);
            st_next = (op_reg == FPES_OP_CHIP_ERASE) ? FPES_POLL : FPES_DONE;
          end
        end
      end
      FPES_DATA:
      begin
        // idx 0: count word, 1: pairs, 2: confirm
        cyc.req = 1'b1;
        cyc.addr = sa_reg;
        if (idx_reg == 3'h0)
          cyc.wdata = 16'(wc_reg);
        else if (idx_reg == 3'h1)
        begin
          cyc.req    = wr_valid_i;
          wr_ready_o = cyc.ack;
          cyc.addr   = wr_addr_i;
          cyc.wdata  = wr_data_i;
        end
        else
          cyc.wdata = `FPES_CMD_WB_CONFIRM;
        if (cyc.ack)
        begin
          if (idx_reg == 3'h1)
          begin
            la_next = wr_addr_i;
            ld_next = wr_data_i;
            if (wc_reg == '0)
              idx_next = 3'h2;
            else
              wc_next = wc_reg - 1'b1;
          end
          else if (idx_reg == 3'h0)
            idx_next = 3'h1;
          else
            st_next = FPES_POLL;
        end
      end
      FPES_SECTW:
      begin
        // Append further sectors inside the accept window
        if (start_i && more_sect_i && gap_reg != 16'h0)
        begin
          sa_next  = sect_addr_i;
          idx_next = 3'h5;
          st_next  = FPES_ISSUE;
        end
        else if (!more_sect_i || gap_reg == 16'h0)
          st_next = FPES_POLL;
      end
      FPES_POLL, FPES_RECHK:
      begin
        cyc.req  = 1'b1;
        cyc.rd   = 1'b1;
        cyc.addr = (op_reg == FPES_OP_BUF_PROG) ? la_reg : sa_reg;
        if (cyc.ack)
        begin
          // Erase passes on polling bit high, buffer on polling bit equal to data
          if (cyc.rdata[`FPES_BIT_POLL] == (op_reg != FPES_OP_BUF_PROG || ld_reg[`FPES_BIT_POLL]))
          begin
            pass_next = 1'b1;
            st_next   = FPES_DONE;
          end
          else if (st_reg == FPES_RECHK || (op_reg != FPES_OP_BUF_PROG && cyc.rdata[`FPES_BIT_FAIL]))
          begin
            fail_next = 1'b1;
            st_next   = FPES_DONE;
          end
          else if (cyc.rdata[`FPES_BIT_FAIL])
            st_next = FPES_RECHK;
          else if (cyc.rdata[`FPES_BIT_ABORT])
          begin
            abt_next = 1'b1;
            st_next  = FPES_DONE;
          end
        end
      end
      FPES_DONE:
      begin
        done_next = 1'b1;
        st_next   = FPES_IDLE;
      end
      default: st_next = FPES_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_reg   <= FPES_IDLE;
      op_reg   <= FPES_OP_RESET;
      idx_reg  <= 3'h0;
      wc_reg   <= '0;
      sa_reg   <= 24'h000000;
      la_reg   <= 24'h000000;
      ld_reg   <= 16'h0000;
      gap_reg  <= 16'h0000;
      rs_reg   <= 16'h0000;
      pass_reg <= 1'b0;
      fail_reg <= 1'b0;
      abt_reg  <= 1'b0;
      done_reg <= 1'b0;
      hv_reg   <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      op_reg   <= op_next;
      idx_reg  <= idx_next;
      wc_reg   <= wc_next;
      sa_reg   <= sa_next;
      la_reg   <= la_next;
      ld_reg   <= ld_next;
      gap_reg  <= gap_next;
      rs_reg   <= rs_next;
      pass_reg <= pass_next;
      fail_reg <= fail_next;
      abt_reg  <= abt_next;
      done_reg <= done_next;
      hv_reg   <= hv_next;
    end
  end

  // Outputs
  assign busy_o     = (st_reg != FPES_IDLE);
  assign done_o     = done_reg;
  assign pass_o     = pass_reg;
  assign fail_o     = fail_reg;
  assign aborted_o  = abt_reg;
  assign accel_hv_o = hv_reg;
endmodule : fpes_sequencer

// ### fpes_map.svh
// Purpose: Constants for the flash command sequencer (host side)
// Assumes: x16 parallel NOR flash, asynchronous write cycles
// Notes:   Command codes, unlock addresses, timing figures
// Operation
// - Bypass buffer abort uses full three-cycle reset
// - Unlock sectors before raising high voltage
// - Load, count minus one, pairs, then confirm
// - Poll last address; recheck polling on fail (code rechecks for buffer program only; erase fails at once)
// - Abort bit: abort reset; fail: plain reset
// - Prefer dedicated program suspend/resume codes
// - Keep resume-to-suspend interval before suspending
// - Chip erase is six bus writes
// - Extra sectors spaced under 50 us
`ifndef FPES_MAP_SVH
`define FPES_MAP_SVH
//------------------------------------------------------------
// Unlock addresses and data
//------------------------------------------------------------
`define FPES_UNLOCK_ADDR1   24'h000555
`define FPES_UNLOCK_ADDR2   24'h0002AA
`define FPES_UNLOCK_DATA1   16'h00AA
`define FPES_UNLOCK_DATA2   16'h0055
//------------------------------------------------------------
// Command codes
//------------------------------------------------------------
`define FPES_CMD_ERASE_SETUP  16'h0080
`define FPES_CMD_CHIP_ERASE   16'h0010
`define FPES_CMD_SECT_ERASE   16'h0030
`define FPES_CMD_WB_LOAD      16'h0025
`define FPES_CMD_WB_CONFIRM   16'h0029
`define FPES_CMD_ABORT_RESET  16'h00F0
`define FPES_CMD_RESET        16'h00F0
`define FPES_CMD_PGM_SUSPEND  16'h0051
`define FPES_CMD_PGM_RESUME   16'h0050
//------------------------------------------------------------
// Status bit positions
//------------------------------------------------------------
`define FPES_BIT_POLL     7
`define FPES_BIT_TOGGLE   6
`define FPES_BIT_FAIL     5
`define FPES_BIT_ETIMER   3
`define FPES_BIT_ABORT    1
//------------------------------------------------------------
// Timing, clock at 25 MHz
//------------------------------------------------------------
`define FPES_CLK_PERIOD_NS      40
`define FPES_SECT_GAP_US        50
`define FPES_SECT_GAP_CYC       ((`FPES_SECT_GAP_US*1000)/`FPES_CLK_PERIOD_NS - 1)
`define FPES_RES_SUS_US         5
`define FPES_RES_SUS_CYC        ((`FPES_RES_SUS_US*1000+`FPES_CLK_PERIOD_NS-1)/`FPES_CLK_PERIOD_NS)
`define FPES_WE_LOW_CYC         3'h2
`define FPES_WE_HIGH_CYC        3'h2
`endif

// ### fpes_pkg.sv
// Purpose: Types for the flash command sequencer
// Assumes: Used with fpes_map.svh
// Notes:   Operation and state encodings
package fpes_pkg;
  // Host-side operation requests
  typedef enum logic [2:0] {
    FPES_OP_CHIP_ERASE = 3'h0,
    FPES_OP_SECT_ERASE = 3'h1,
    FPES_OP_BUF_PROG   = 3'h2,
    FPES_OP_SUSPEND    = 3'h3,
    FPES_OP_RESUME     = 3'h4,
    FPES_OP_RESET      = 3'h5,
    FPES_OP_ABORT_RST  = 3'h6
  } fpes_op_t;
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    FPES_IDLE   = 7'h01,
    FPES_ISSUE  = 7'h02,
    FPES_DATA   = 7'h04,
    FPES_SECTW  = 7'h08,
    FPES_POLL   = 7'h10,
    FPES_RECHK  = 7'h20,
    FPES_DONE   = 7'h40
  } fpes_state_t;
endpackage : fpes_pkg

// ### fpes_wr_if.sv
// Purpose: Write-cycle request carrier between sequencer and pin driver
// Assumes: Single clock
// Notes:   req held until ack
`timescale 1ns/1ps
interface fpes_wr_if;
  logic        req;   // Write or read cycle requested
  logic        rd;    // High for a read cycle
  logic [23:0] addr;  // Cycle address
  logic [15:0] wdata; // Write data
  logic        ack;   // Cycle finished, one pulse
  logic [15:0] rdata; // Read data
  modport seq (output req, rd, addr, wdata, input ack, rdata);
  modport drv (input req, rd, addr, wdata, output ack, rdata);
endinterface : fpes_wr_if

// ### fpes_bus_cycle.sv
// Purpose: Drives one asynchronous bus cycle on the flash pins
// Assumes: Write strobe rising edge latches data
// Notes:   Fixed low and high phase lengths
`timescale 1ns/1ps
`include "fpes_map.svh"
module fpes_bus_cycle
  import fpes_pkg::*;
(
  input  wire logic clk_i,       // Clock
  input  wire logic reset_n_i,   // Async reset, active low
  fpes_wr_if.drv    cyc,         // Cycle requests
  output logic [23:0] addr_o,    // Flash address
  output logic [15:0] dq_o,      // Data out
  output logic        dq_oe_o,   // Data drive enable
  input  wire logic [15:0] dq_i, // Data in
  output logic        we_n_o,    // Write strobe
  output logic        oe_n_o     // Output enable strobe
);
  //----------------------------------------------------------
  // Phase counter and strobes
  //----------------------------------------------------------
  logic [1:0]  ph_reg, ph_next;       // 0 idle, 1 low, 2 high
  logic [2:0]  cnt_reg, cnt_next;     // Phase cycles
  logic [23:0] a_reg, a_next;         // Address
  logic [15:0] d_reg, d_next;         // Write data
  logic [15:0] r_reg, r_next;         // Read data
  logic        rd_reg, rd_next;       // Read cycle
  logic        ack_reg, ack_next;     // Done pulse

  // Next-state logic
  always_comb
  begin
    ph_next  = ph_reg;
    cnt_next = cnt_reg;
    a_next   = a_reg;
    d_next   = d_reg;
    r_next   = r_reg;
    rd_next  = rd_reg;
    ack_next = 1'b0;
    case (ph_reg)
      2'h0:
      begin
        if (cyc.req && !ack_reg)
        begin
          a_next   = cyc.addr;
          d_next   = cyc.wdata;
          rd_next  = cyc.rd;
          cnt_next = `FPES_WE_LOW_CYC;
          ph_next  = 2'h1;
        end
      end
      2'h1:
      begin
        if (cnt_reg == 3'h0)
        begin
          if (rd_reg)
            r_next = dq_i;
          cnt_next = `FPES_WE_HIGH_CYC;
          ph_next  = 2'h2;
        end
        else
          cnt_next = cnt_reg - 3'h1;
      end
      2'h2:
      begin
        if (cnt_reg == 3'h0)
        begin
          ack_next = 1'b1;
          ph_next  = 2'h0;
        end
        else
          cnt_next = cnt_reg - 3'h1;
      end
      default: ph_next = 2'h0;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ph_reg  <= 2'h0;
      cnt_reg <= 3'h0;
      a_reg   <= 24'h000000;
      d_reg   <= 16'h0000;
      r_reg   <= 16'h0000;
      rd_reg  <= 1'b0;
      ack_reg <= 1'b0;
    end
    else
    begin
      ph_reg  <= ph_next;
      cnt_reg <= cnt_next;
      a_reg   <= a_next;
      d_reg   <= d_next;
      r_reg   <= r_next;
      rd_reg  <= rd_next;
      ack_reg <= ack_next;
    end
  end

  // Pin drive; rising strobe at low-to-high phase
  assign addr_o    = a_reg;
  assign dq_o      = d_reg;
  assign dq_oe_o   = (ph_reg != 2'h0) && !rd_reg;
  assign we_n_o    = !((ph_reg == 2'h1) && !rd_reg);
  assign oe_n_o    = !((ph_reg == 2'h1) && rd_reg);
  assign cyc.ack   = ack_reg;
  assign cyc.rdata = r_reg;
endmodule : fpes_bus_cycle

// ### fpes_sequencer_sva.sv
// Purpose: Pin and flag checks for the sequencer
// Assumes: Bound to fpes_sequencer
// Notes:   Single clock domain
`timescale 1ns/1ps
module fpes_sequencer_sva
  import fpes_pkg::*;
(
  input wire logic        clk_i,      // Clock
  input wire logic        reset_n_i,  // Reset, active low
  input wire logic        start_i,    // Start request
  input wire logic [2:0]  op_i,       // Op code
  input wire logic        busy_o,     // Busy
  input wire logic        done_o,     // Done pulse
  input wire logic        pass_o,     // Pass flag
  input wire logic        fail_o,     // Fail flag
  input wire logic        aborted_o,  // Abort flag
  input wire logic        accel_en_i, // Accel request
  input wire logic        unlocked_i, // Sectors unlocked
  input wire logic        accel_hv_o, // High voltage select
  input wire logic [23:0] fl_addr_o,  // Flash address
  input wire logic [15:0] fl_dq_o,    // Flash data out
  input wire logic        fl_dq_oe_o, // Data enable
  input wire logic        fl_we_n_o,  // Write strobe
  input wire logic        fl_oe_n_o   // Read strobe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic       ce_reg; // Chip erase in flight
  logic [3:0] wc_reg; // Strobes since start
  //------------------------------------------------------------
  // Strobe counter per operation
  //------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ce_reg <= 1'b0;
      wc_reg <= 4'h0;
    end
    else if (start_i && !busy_o)
    begin
      ce_reg <= (op_i == FPES_OP_CHIP_ERASE);
      wc_reg <= 4'h0;
    end
    else if ($rose(fl_we_n_o) && wc_reg != 4'hF)
      wc_reg <= wc_reg + 4'h1;
  end
  AST_CHIP_SIX: assert property (done_o && ce_reg |-> wc_reg == 4'h6)
    else $error("chip erase strobe count wrong");
  AST_WE_LOW: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*3] ##1 fl_we_n_o)
    else $error("write strobe low phase wrong");
  AST_LATCH: assert property ($rose(fl_we_n_o) |-> $stable(fl_addr_o) && $stable(fl_dq_o))
    else $error("address or data moved under strobe");
  AST_NO_FIGHT: assert property (!fl_oe_n_o |-> fl_we_n_o && !fl_dq_oe_o)
    else $error("read overlaps drive");
  AST_HV_ON: assert property (accel_en_i && unlocked_i |=> accel_hv_o)
    else $error("high voltage not raised");
  AST_HV_OFF: assert property (!(accel_en_i && unlocked_i) |=> !accel_hv_o)
    else $error("high voltage not dropped");
  AST_DONE: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  AST_FLAGS: assert property (pass_o |-> !fail_o && !aborted_o)
    else $error("pass with fail or abort");
  AST_IDLE: assert property (!busy_o |-> fl_we_n_o && fl_oe_n_o)
    else $error("strobe active while idle");
endmodule : fpes_sequencer_sva
bind fpes_sequencer fpes_sequencer_sva chk_u (.clk_i, .reset_n_i, .start_i, .op_i,
  .busy_o, .done_o, .pass_o, .fail_o, .aborted_o, .accel_en_i, .unlocked_i,
  .accel_hv_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_we_n_o, .fl_oe_n_o);

// ### fpes_flash_model.sv
// Purpose: Behavioural flash device on the parallel pins
// Assumes: Strobes held several cycles of clk_i
// Notes:   Sector is address bits 23 to 16
`timescale 1ns/1ps
module fpes_flash_model
#(
  parameter int BUSY = 40, // Embedded op length
  parameter int WIN  = 20  // Sector accept window
)
(
  input  wire logic        clk_i,  // Reference clock
  input  wire logic [23:0] a_i,    // Address
  input  wire logic [15:0] d_i,    // Data from host
  input  wire logic        we_n_i, // Write strobe
  input  wire logic        oe_n_i, // Read strobe
  input  wire logic        fail_i, // Force timeout fail
  output logic      [15:0] d_o     // Data to host
);
  logic [15:0] last;             // Data at polled place
  logic [7:0]  sa, left;         // Load sector, words left
  logic [1:0]  ld;               // Load phase
  logic        abt, fl, sus, tog; // Status flags
  logic        we_d, oe_d;       // Strobe history
  int          bsy, win;         // Busy and window counts
  initial {last, sa, left, ld, abt, fl, sus, tog, we_d, oe_d, bsy, win} = '0;
  //------------------------------------------------------------
  // Command decode at write strobe rise
  //------------------------------------------------------------
  always @(posedge clk_i)
  begin
    we_d <= we_n_i;
    oe_d <= oe_n_i;
    if (oe_n_i && !oe_d)
      tog <= !tog;
    if (win > 0)
      win <= win - 1;
    else if (bsy > 0 && !sus)
      bsy <= bsy - 1;
    if (we_n_i && !we_d)
    begin
      if (d_i == 16'h00F0 && (abt || fl || bsy == 0))
      begin
        {abt, fl, ld} <= 4'h0;
        bsy <= 0;
      end
      else if (ld == 2'h1)
        {left, ld} <= {d_i[7:0], 2'h2};
      else if (ld == 2'h2)
      begin
        abt <= abt | (a_i[23:16] != sa);
        last <= d_i;
        left <= left - 8'h1;
        if (left == 8'h0)
          ld <= 2'h3;
      end
      else if (ld == 2'h3)
      begin
        ld <= 2'h0;
        fl <= fail_i;
        bsy <= BUSY;
      end
      else if (d_i == 16'h0025)
        {ld, sa} <= {2'h1, a_i[23:16]};
      else if (bsy > 0 || win > 0)
      begin
        if (d_i == 16'h0051 || d_i == 16'h00B0)
          sus <= 1'b1;
        if (d_i == 16'h0050 || d_i == 16'h0030)
          sus <= 1'b0;
        if (d_i == 16'h0030 && win > 0)
          win <= WIN;
      end
      else if (d_i == 16'h0010 || d_i == 16'h0030)
      begin
        last <= 16'hFFFF;
        bsy <= BUSY;
        win <= (d_i == 16'h0030) ? WIN : 0;
      end
    end
  end
  //------------------------------------------------------------
  // Read path; released bus shows inverted data
  //------------------------------------------------------------
  always_comb
    if (oe_n_i)
      d_o = ~last;
    else if (bsy > 0 || abt || fl)
      d_o = {8'h00, ~last[7], tog, fl, 1'b0, win == 0, 1'b0, abt, 1'b0};
    else
      d_o = last;
endmodule : fpes_flash_model

// ### tb_flash_program_erase_sequencer.sv
// Purpose: Directed checks of the flash sequencer
// Assumes: Device model on the far side
// Notes:   Inputs change 1 ns after rising edge
`timescale 1ns/1ps
`include "fpes_map.svh"
module tb_flash_program_erase_sequencer
  import fpes_pkg::*;
;
  logic        clk_i, reset_n_i, start_i, more_sect_i, accel_en_i, unlocked_i;
  logic        wr_ready_o, wr_valid_i, busy_o, done_o, pass_o, fail_o, aborted_o;
  logic        accel_hv_o, fl_dq_oe_o, fl_we_n_o, fl_oe_n_o, fail_i, bad, we_d, rdy_q;
  logic [2:0]  op_i;
  logic [7:0]  count_i;
  logic [23:0] sect_addr_i, wr_addr_i, fl_addr_o;
  logic [15:0] wr_data_i, fl_dq_o, fl_dq_i, dev_q;
  logic [15:0] wd [128];
  logic [23:0] wa [128];
  int          wn, b, k, idx, cyc, error_cnt, n_tests;
  logic [15:0] ce [6];
  assign wr_addr_i = {(bad && idx == 2) ? 8'h03 : sect_addr_i[23:16], 8'h00, 8'(idx)};
  assign wr_data_i = 16'h1230 + 16'(idx);
  assign fl_dq_i   = fl_dq_oe_o ? fl_dq_o : dev_q;
  fpes_sequencer dut_u (.clk_i, .reset_n_i, .start_i, .op_i, .sect_addr_i, .count_i,
    .more_sect_i, .accel_en_i, .unlocked_i, .wr_addr_i, .wr_data_i, .wr_ready_o,
    .wr_valid_i, .busy_o, .done_o, .pass_o, .fail_o, .aborted_o, .accel_hv_o,
    .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i, .fl_we_n_o, .fl_oe_n_o);
  fpes_flash_model dev_u (.clk_i, .a_i(fl_addr_o), .d_i(fl_dq_o),
    .we_n_i(fl_we_n_o), .oe_n_i(fl_oe_n_o), .fail_i, .d_o(dev_q));
  //------------------------------------------------------------
  // Clock, strobe log, word feed, timeout
  //------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(negedge clk_i)
  begin
    if (fl_we_n_o && !we_d)
    begin
      wa[wn] = fl_addr_o;
      wd[wn] = fl_dq_o;
      wn++;
    end
    we_d = fl_we_n_o;
    rdy_q = wr_ready_o;
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      summarize();
    end
  end
  always @(posedge clk_i)
    #1 if (rdy_q) idx++;
  //------------------------------------------------------------
  // Tasks
  //------------------------------------------------------------
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk16
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask : chk1
  task automatic run(input logic [2:0] op, input logic [23:0] sa, input logic [7:0] n, input int lim);
    int t;
    b = wn;
    idx = 0;
    op_i = op;
    sect_addr_i = sa;
    count_i = n;
    start_i = 1'b1;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    for (t = 0; t < lim && done_o !== 1'b1; t++)
    begin
      @(posedge clk_i);
      #1;
    end
    if (lim > 100 && t == lim)
      chk1("done", 1'b1, 1'b0);
  endtask : run
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial
  begin
    {reset_n_i, start_i, more_sect_i, accel_en_i, unlocked_i, fail_i, bad, we_d, rdy_q} = 9'h002;
    {op_i, count_i, sect_addr_i, wn, idx, cyc, error_cnt, n_tests} = '0;
    wr_valid_i = 1'b1;
    ce = '{`FPES_UNLOCK_DATA1, `FPES_UNLOCK_DATA2, `FPES_CMD_ERASE_SETUP,
           `FPES_UNLOCK_DATA1, `FPES_UNLOCK_DATA2, `FPES_CMD_CHIP_ERASE};
    repeat (5) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    accel_en_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk1("accel_hv", 1'b0, accel_hv_o);
    unlocked_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk1("accel_hv", 1'b1, accel_hv_o);
    accel_en_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk1("accel_hv", 1'b0, accel_hv_o);
    run(FPES_OP_CHIP_ERASE, 24'h000000, 8'h00, 3000);
    chk16("ce_writes", 16'h0006, 16'(wn - b));
    for (k = 0; k < 6; k++)
      chk16("ce_data", ce[k], wd[b + k]);
    chk1("ce_pass", 1'b1, pass_o);
    run(FPES_OP_SECT_ERASE, 24'h050000, 8'h00, 3000);
    chk16("se_cmd", `FPES_CMD_SECT_ERASE, wd[wn - 1]);
    chk16("se_sector", 16'h0500, wa[wn - 1][23:8]);
    chk1("se_pass", 1'b1, pass_o);
    run(FPES_OP_BUF_PROG, 24'h020000, 8'h03, 3000);
    chk16("bp_writes", 16'h0009, 16'(wn - b));
    chk16("bp_count", 16'h0003, wd[b + 3]);
    chk16("bp_confirm", `FPES_CMD_WB_CONFIRM, wd[wn - 1]);
    chk1("bp_pass", 1'b1, pass_o);
    bad = 1'b1;
    run(FPES_OP_BUF_PROG, 24'h020000, 8'h03, 3000);
    chk1("aborted", 1'b1, aborted_o);
    bad = 1'b0;
    run(FPES_OP_ABORT_RST, 24'h020000, 8'h00, 3000);
    chk16("ar_writes", 16'h0003, 16'(wn - b));
    chk16("ar_cmd", 16'h00F0, wd[wn - 1]);
    fail_i = 1'b1;
    run(FPES_OP_BUF_PROG, 24'h020000, 8'h01, 3000);
    chk1("fail", 1'b1, fail_o);
    fail_i = 1'b0;
    run(FPES_OP_RESET, 24'h000000, 8'h00, 3000);
    chk16("rst_cmd", 16'h00F0, wd[wn - 1]);
    run(FPES_OP_SUSPEND, 24'h000000, 8'h00, 3000);
    chk16("sus_cmd", 16'h0051, wd[wn - 1]);
    run(FPES_OP_RESUME, 24'h000000, 8'h00, 3000);
    chk16("res_cmd", 16'h0050, wd[wn - 1]);
    run(FPES_OP_SUSPEND, 24'h000000, 8'h00, 20);
    chk16("sus_early", 16'h0000, 16'(wn - b));
    repeat (130) @(posedge clk_i);
    #1 run(FPES_OP_SUSPEND, 24'h000000, 8'h00, 3000);
    chk16("sus_late", 16'h0051, wd[wn - 1]);
    summarize();
  end
endmodule : tb_flash_program_erase_sequencer
